/* File: src/adc_seq_pkg.sv */
// Package: register map, field layout, reset values and timing constants
package adc_seq_pkg;
	localparam logic [11:0] OFF_CONTROL_ONE = 12'h2D0; // Index B4 times 4
	localparam logic [11:0] OFF_CONTROL_TWO = 12'h2D4; // Index B5 times 4
	localparam logic [11:0] OFF_RESULT_LOW  = 12'h2E8; // Index BA times 4
	localparam logic [11:0] OFF_RESULT_HIGH = 12'h2EC; // Index BB times 4
	localparam logic [11:0] OFF_RANDOM      = 12'h300; // LFSR value, own choice
	localparam logic [7:0]  IDX_CONTROL_ONE = 8'hB4;
	localparam logic [7:0]  IDX_CONTROL_TWO = 8'hB5;
	localparam logic [7:0]  IDX_RESULT_LOW  = 8'hBA;
	localparam logic [7:0]  IDX_RESULT_HIGH = 8'hBB;
	localparam int POS_DONE    = 7;
	localparam int POS_START   = 6;
	localparam int POS_TRIG    = 4;
	localparam int POS_RANDOM_STEP_CONTROL   = 2;
	localparam int POS_REF     = 6;
	localparam int POS_DEC     = 4;
	localparam logic [1:0]  TRIG_RESET  = 2'h3;
	localparam logic [1:0]  TRIG_PIN    = 2'h0;
	localparam logic [1:0]  TRIG_FREE   = 2'h1;
	localparam logic [1:0]  TRIG_TIMER  = 2'h2;
	localparam logic [1:0]  TRIG_SW     = 2'h3;
	localparam logic [1:0]  RSTEP_IDLE  = 2'h0;
	localparam logic [1:0]  RSTEP_GO    = 2'h1;
	localparam logic [1:0]  LOW_RESERVED_RESET = 2'h3;
	localparam logic [1:0]  REF_RESET   = 2'h0;
	localparam logic [1:0]  DEC_RESET   = 2'h1;
	localparam logic [3:0]  CHAN_RESET  = 4'h0;
	localparam logic [3:0]  CHAN_DIFF_FIRST   = 4'h8;
	localparam logic [3:0]  CHAN_SINGLE_FIRST = 4'hC;
	localparam logic [15:0] LFSR_RESET  = 16'h0000;
	localparam int LFSR_STEPS  = 13;
	localparam int SETTLE_CLOCKS = 16;
	localparam int CONV_CLK_DIV  = 6;
	localparam int CLOCK_MHZ     = 250;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam logic [9:0] DEC_TABLE [4] = '{10'd64, 10'd128, 10'd256,
		10'd512};
	typedef struct packed {
		logic [1:0] reference;
		logic [1:0] decimation;
		logic [3:0] channel;
	} conv_setting_type;
endpackage

/* File: src/conv_timer.sv */
// One conversion: settle plus decimation count in converter clocks
`timescale 1ns/1ps
module conv_timer
	import adc_seq_pkg::*;
#(
	parameter int DIV = CONV_CLK_DIV
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       start,
	input  wire logic [1:0] decimation,
	output logic            done
);
	logic [2:0]  pre_q;
	logic [10:0] left_q;
	logic        busy_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pre_q  <= 3'h0;
			left_q <= 11'h000;
			busy_q <= 1'b0;
			done   <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy_q <= 1'b1;
				pre_q  <= 3'h0;
				// Settle time applies whatever the decimation
				left_q <= 11'(DEC_TABLE[decimation]) + 11'(SETTLE_CLOCKS);
			end else if (busy_q) begin
				if (pre_q == 3'(DIV - 1)) begin
					pre_q <= 3'h0;
					if (left_q == 11'h001) begin
						busy_q <= 1'b0;
						done   <= 1'b1;
					end
					left_q <= left_q - 11'h001;
				end else begin
					pre_q <= pre_q + 3'h1;
				end
			end
		end
	end
endmodule // conv_timer

/* File: src/lfsr_step.sv */
// 16-bit random generator advanced by an unrolled multi-shift step
`timescale 1ns/1ps
module lfsr_step
	import adc_seq_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        step,
	output logic [15:0]      value
);
	function automatic logic [15:0] advance(input logic [15:0] s);
		logic [15:0] r;
		r = s;
		for (int i = 0; i < LFSR_STEPS; i++) begin
			r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10] ^ 1'b1};
		end
		return r;
	endfunction

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			value <= LFSR_RESET;
		end else if (step) begin
			value <= advance(value);
		end
	end
endmodule // lfsr_step

/* File: src/adc_sequence_control_regs.sv */
// Converter control and result registers with sequence engine, APB slave
//
// Operation
// - High result byte shows result bits 11:4
// - Done flag sets on completion, clears on high result byte read
// - Repeat completion keeps done set, no overrun
// - Start bit starts only if trigger 11, idle
// - Start bit reads one until sequence ends
// - Trigger select picks pin, free, timer, software
// - Free-running mode repeats sequences back to back
// - Random control 01 advances LFSR one step
// - Random control returns to 00 when done
// - Reference select picks source for the sequence
// - Decimation select picks 64 to 512, reset 01
// - Codes 0-7 convert single inputs from zero
// - Codes 8-11 convert differential pairs from code 8
// - Codes 12-15 perform exactly one conversion
// - Channel field reads back the single code for 12-15, end plus one for sequences
// - Sequence codes read back as written plus one once the sequence ends
// - Low result byte holds bits 3:0 high
// - Conversion takes decimation plus sixteen converter clocks
`timescale 1ns/1ps
module adc_sequence_control_regs
	import adc_seq_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        external_trigger_pin,
	input  wire logic        timer_compare_event,
	input  wire logic [11:0] modulator_result,
	output logic [1:0]       active_reference,
	output logic [3:0]       active_channel,
	output logic             conversion_active
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_NEXT = 3'b100
	} seq_state_type;

	seq_state_type    state_q;
	conv_setting_type setting_q;
	logic [1:0]  trigger_select_q;
	logic [1:0]  random_step_control_q;
	logic [1:0]  reserved_low_q;
	logic        sw_start_bit_q;
	logic        done_flag_q;
	logic [1:0]  sequence_reference_select_q;
	logic [1:0]  sequence_decimation_select_q;
	logic [3:0]  sequence_end_channel_q;
	logic [3:0]  end_written_q;
	logic [3:0]  channel_q;
	logic [11:0] result_q;
	logic        pin_prev_q;
	logic        step_pending_q;
	logic        conv_start_q;
	logic        conv_done;
	logic [15:0] random_value;
	logic        wr_access;
	logic        rd_access;
	logic        wr_one;
	logic        wr_two;
	logic        trigger;
	logic        last_conv;

	function automatic logic hits(input logic [11:0] a,
		input logic [11:0] off);
		return a == off;
	endfunction

	assign wr_access = psel & penable & pwrite & pstrb[0];
	assign rd_access = psel & penable & ~pwrite;
	assign wr_one    = wr_access & hits(paddr, OFF_CONTROL_ONE);
	assign wr_two    = wr_access & hits(paddr, OFF_CONTROL_TWO);

	// Trigger selection; software start only in mode 11
	always_comb begin
		unique case (trigger_select_q)
			TRIG_PIN:   trigger = external_trigger_pin & ~pin_prev_q;
			TRIG_FREE:  trigger = 1'b1;
			TRIG_TIMER: trigger = timer_compare_event;
			TRIG_SW:    trigger = wr_one & pwdata[POS_START];
		endcase
	end

	// Single-conversion codes end at once; sequences at the named end
	assign last_conv = (setting_q.channel >= CHAN_SINGLE_FIRST) ||
		(channel_q == setting_q.channel);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= external_trigger_pin;
		end
	end

	// Sequence engine
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q      <= ST_IDLE;
			setting_q    <= '{REF_RESET, DEC_RESET, CHAN_RESET};
			channel_q    <= CHAN_RESET;
			conv_start_q <= 1'b0;
		end else begin
			conv_start_q <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					// Triggers outside idle are simply dropped
					if (trigger) begin
						// Snapshot so writes mid-sequence do no harm
						// Written end code, not the read-back value, so
						// free running does not creep upward
						setting_q <= '{sequence_reference_select_q,
							sequence_decimation_select_q,
							end_written_q};
						if (end_written_q >= CHAN_SINGLE_FIRST) begin
							channel_q <= end_written_q;
						end else if (end_written_q >=
							CHAN_DIFF_FIRST) begin
							channel_q <= CHAN_DIFF_FIRST;
						end else begin
							channel_q <= CHAN_RESET;
						end
						conv_start_q <= 1'b1;
						state_q      <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (conv_done) begin
						state_q <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					if (last_conv) begin
						state_q <= ST_IDLE;
					end else begin
						channel_q    <= channel_q + 4'h1;
						conv_start_q <= 1'b1;
						state_q      <= ST_CONV;
					end
				end
			endcase
		end
	end

	conv_timer #(.DIV(CONV_CLK_DIV)) u_timer (
		.clock      (clock),
		.rst_n      (rst_n),
		.start      (conv_start_q),
		.decimation (setting_q.decimation),
		.done       (conv_done)
	);

	// Result capture and done flag; set wins over read clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			result_q    <= RESULT_RESET;
			done_flag_q <= 1'b0;
		end else begin
			if (conv_done) begin
				result_q    <= modulator_result;
				done_flag_q <= 1'b1;
			end else if (rd_access && hits(paddr, OFF_RESULT_HIGH)) begin
				done_flag_q <= 1'b0;
			end
		end
	end

	// Control register one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			trigger_select_q      <= TRIG_RESET;
			reserved_low_q        <= LOW_RESERVED_RESET;
			sw_start_bit_q        <= 1'b0;
			random_step_control_q <= RSTEP_IDLE;
			step_pending_q        <= 1'b0;
		end else begin
			step_pending_q <= 1'b0;
			if (wr_one) begin
				trigger_select_q <= pwdata[POS_TRIG +: 2];
				// Kept as written; software is expected to write 11
				reserved_low_q   <= pwdata[1:0];
			end
			if (state_q == ST_IDLE && trigger &&
				trigger_select_q == TRIG_SW) begin
				sw_start_bit_q <= 1'b1;
			end else if (state_q == ST_NEXT && last_conv) begin
				sw_start_bit_q <= 1'b0;
			end
			if (wr_one && pwdata[POS_RANDOM_STEP_CONTROL +: 2] == RSTEP_GO) begin
				random_step_control_q <= RSTEP_GO;
				step_pending_q        <= 1'b1;
			end else if (wr_one) begin
				random_step_control_q <= pwdata[POS_RANDOM_STEP_CONTROL +: 2];
			end else if (random_step_control_q == RSTEP_GO &&
				!step_pending_q) begin
				random_step_control_q <= RSTEP_IDLE;
			end
		end
	end

	lfsr_step u_lfsr (
		.clock (clock),
		.rst_n (rst_n),
		.step  (step_pending_q),
		.value (random_value)
	);

	// Control register two; channel field reports end plus one after a sequence
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			end_written_q <= CHAN_RESET;
		end else if (wr_two) begin
			end_written_q <= pwdata[3:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sequence_reference_select_q  <= REF_RESET;
			sequence_decimation_select_q <= DEC_RESET;
			sequence_end_channel_q       <= CHAN_RESET;
		end else begin
			if (wr_two) begin
				sequence_reference_select_q  <= pwdata[POS_REF +: 2];
				sequence_decimation_select_q <= pwdata[POS_DEC +: 2];
				sequence_end_channel_q       <= pwdata[3:0];
			end else if (state_q == ST_NEXT && last_conv) begin
				// Sequences read back as end plus one
				if (setting_q.channel < CHAN_SINGLE_FIRST) begin
					sequence_end_channel_q <= setting_q.channel + 4'h1;
				end else begin
					sequence_end_channel_q <= setting_q.channel;
				end
			end
		end
	end

	// Outputs to the analog side
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			active_reference  <= REF_RESET;
			active_channel    <= CHAN_RESET;
			conversion_active <= 1'b0;
		end else begin
			active_reference  <= setting_q.reference;
			active_channel    <= channel_q;
			conversion_active <= (state_q != ST_IDLE);
		end
	end

	// APB answer: zero wait states, error on unmapped offsets
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				prdata <= 32'h0000_0000;
				unique case (paddr)
					OFF_CONTROL_ONE: prdata[7:0] <= {done_flag_q,
						sw_start_bit_q, trigger_select_q,
						random_step_control_q, reserved_low_q};
					OFF_CONTROL_TWO: prdata[7:0] <= {
						sequence_reference_select_q,
						sequence_decimation_select_q,
						sequence_end_channel_q};
					OFF_RESULT_LOW:  prdata[7:0] <= {result_q[3:0],
						4'h0};
					OFF_RESULT_HIGH: prdata[7:0] <= result_q[11:4];
					OFF_RANDOM:      prdata[15:0] <= random_value;
					default:         pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule // adc_sequence_control_regs

/* File: tb/adc_seq_props.sv */
// Checker: bus timing and sequence engine relations at the block ports
`timescale 1ns/1ps
module adc_seq_props
	import adc_seq_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  active_reference,
	input wire logic        conversion_active
);
	logic [15:0] run_q;
	logic        mapped;
	assign mapped = paddr inside {OFF_CONTROL_ONE, OFF_CONTROL_TWO,
		OFF_RESULT_LOW, OFF_RESULT_HIGH, OFF_RANDOM};
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			run_q <= 16'h0000;
		else
			run_q <= conversion_active ? run_q + 16'h0001 : 16'h0000;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_READY_TIMING: assert property (pready == $past(psel && !penable))
		else $error("pready not one cycle after setup");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_UNMAPPED: assert property (psel && !penable |=> pslverr == !$past(mapped))
		else $error("pslverr does not match address map");
	AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	AST_SW_START: assert property (psel && penable && pready && pwrite
		&& paddr == OFF_CONTROL_ONE && pstrb[0] && pwdata[6]
		&& pwdata[5:4] == TRIG_SW && !conversion_active
		|-> ##[1:4] conversion_active)
		else $error("software start did not begin a sequence");
	// Off by two allowed for the start and stop registers
	AST_MIN_CONV: assert property ($fell(conversion_active) |-> run_q >= 16'h01DE)
		else $error("sequence shorter than one conversion");
	AST_REF_HOLD: assert property (conversion_active && $past(conversion_active)
		|-> $stable(active_reference))
		else $error("reference changed during a sequence");
endmodule // adc_seq_props

bind adc_sequence_control_regs adc_seq_props i_adc_seq_props (.clock, .rst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
	.pslverr, .active_reference, .conversion_active);

/* File: tb/test_adc_sequence_control_regs.sv */
// Self-checking bench for the converter control register block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_adc_sequence_control_regs
	import adc_seq_pkg::*;
();
	typedef struct packed {
		logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e; logic x;
	} reg_row_type;
	typedef struct packed {logic [3:0] code; logic [1:0] dec; int conv;} seq_row_type;
	logic        clock = 1'b0, rst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000, modulator_result = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, pslverr, perr, conversion_active;
	logic        external_trigger_pin = 1'b0, timer_compare_event = 1'b0;
	logic [1:0]  active_reference;
	logic [3:0]  active_channel;
	int          bad_count = 0, num_checks = 0, cyc = 0, t0, n, lo;
	reg_row_type regs [12] = '{
		'{0, OFF_CONTROL_ONE, 0, 8'h33, 0}, '{0, OFF_CONTROL_TWO, 0, 8'h10, 0},
		'{0, OFF_RESULT_HIGH, 0, 0, 0}, '{0, OFF_RESULT_LOW, 0, 0, 0},
		'{0, 12'h010, 0, 0, 1}, '{1, OFF_CONTROL_ONE, 8'h23, 0, 0},
		'{0, OFF_CONTROL_ONE, 0, 8'h23, 0}, '{1, OFF_CONTROL_TWO, 8'hC5, 0, 0},
		'{0, OFF_CONTROL_TWO, 0, 8'hC5, 0}, '{1, OFF_RESULT_HIGH, 8'hFF, 0, 0},
		'{0, OFF_RESULT_HIGH, 0, 0, 0}, '{1, OFF_CONTROL_ONE, 8'h33, 0, 0}};
	seq_row_type seqs [6] = '{'{4'h0, 2'h0, 1}, '{4'h7, 2'h0, 8},
		'{4'h8, 2'h1, 1}, '{4'hB, 2'h0, 4}, '{4'hC, 2'h2, 1}, '{4'hF, 2'h3, 1}};

	adc_sequence_control_regs i_adc_sequence_control_regs (.clock, .rst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .external_trigger_pin, .timer_compare_event,
		.modulator_result, .active_reference, .active_channel,
		.conversion_active);

	always #2 clock = ~clock;
	always @(posedge clock) cyc++;

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 16);
		`CHK(pready, 1'b1)
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic run_len();
		while (conversion_active === 1'b1 && cyc - t0 < 40000) @(posedge clock);
		n = cyc - t0;
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#400000;
		bad_count++;
		conclude();
	end

	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		foreach (regs[i]) begin
			apb(regs[i].w, regs[i].a, regs[i].d);
			if (!regs[i].w) `CHK(perr, regs[i].x)
			if (!regs[i].w && !regs[i].x) `CHK(rd[7:0], regs[i].e)
		end
		$display("Test done: register map");
		foreach (seqs[i]) begin
			modulator_result <= {8'h9C, seqs[i].code};
			apb(1, OFF_CONTROL_TWO, {2'b10, seqs[i].dec, seqs[i].code});
			apb(1, OFF_CONTROL_ONE, 8'h73);
			t0 = cyc;
			repeat (4) @(posedge clock);
			`CHK(conversion_active, 1'b1)
			`CHK(active_reference, 2'b10)
			`CHK(active_channel, seqs[i].code >= 4'hC ? seqs[i].code :
				(seqs[i].code >= 4'h8 ? 4'h8 : 4'h0))
			apb(0, OFF_CONTROL_ONE, 0);
			`CHK(rd[6], 1'b1)
			apb(1, OFF_CONTROL_TWO, {2'b01, seqs[i].dec, seqs[i].code});
			apb(1, OFF_CONTROL_ONE, 8'h73);
			`CHK(active_reference, 2'b10)
			run_len();
			lo = seqs[i].conv * (int'(DEC_TABLE[seqs[i].dec]) + SETTLE_CLOCKS)
				* CONV_CLK_DIV;
			`CHK(n >= lo - 4 && n <= lo + 8 * seqs[i].conv + 8, 1'b1)
			apb(0, OFF_CONTROL_TWO, 0);
			`CHK(rd[7:0], {2'b01, seqs[i].dec, seqs[i].code < 4'hC ? seqs[i].code + 4'h1 : seqs[i].code})
			apb(0, OFF_CONTROL_ONE, 0);
			`CHK(rd[7:6], 2'b10)
			apb(0, OFF_RESULT_HIGH, 0);
			`CHK(rd[7:0], 8'h9C)
			apb(0, OFF_RESULT_LOW, 0);
			`CHK(rd[7:0], {seqs[i].code, 4'h0})
			apb(0, OFF_CONTROL_ONE, 0);
			`CHK(rd[7], 1'b0)
		end
		$display("Test done: sequences");
		apb(1, OFF_CONTROL_TWO, 8'h0C);
		apb(1, OFF_CONTROL_ONE, 8'h23);
		apb(1, OFF_CONTROL_ONE, 8'h63);
		repeat (8) @(posedge clock);
		`CHK(conversion_active, 1'b0)
		timer_compare_event <= 1'b1;
		@(posedge clock);
		timer_compare_event <= 1'b0;
		repeat (4) @(posedge clock);
		`CHK(conversion_active, 1'b1)
		t0 = cyc;
		run_len();
		apb(1, OFF_CONTROL_ONE, 8'h03);
		external_trigger_pin <= 1'b1;
		repeat (4) @(posedge clock);
		`CHK(conversion_active, 1'b1)
		external_trigger_pin <= 1'b0;
		t0 = cyc;
		run_len();
		$display("Test done: trigger sources");
		// Free running: done must come back after it was cleared
		apb(1, OFF_CONTROL_ONE, 8'h13);
		repeat (600) @(posedge clock);
		apb(0, OFF_RESULT_HIGH, 0);
		repeat (600) @(posedge clock);
		apb(0, OFF_CONTROL_ONE, 0);
		`CHK(rd[7], 1'b1)
		apb(1, OFF_CONTROL_ONE, 8'h33);
		t0 = cyc;
		run_len();
		apb(0, OFF_RANDOM, 0);
		lo = int'(rd);
		apb(1, OFF_CONTROL_ONE, 8'h37);
		repeat (LFSR_STEPS + 4) @(posedge clock);
		apb(0, OFF_CONTROL_ONE, 0);
		`CHK(rd[5:0], 6'h33)
		apb(0, OFF_RANDOM, 0);
		`CHK(rd[15:0] != lo[15:0], 1'b1)
		$display("Test done: free run and random step");
		apb(1, OFF_CONTROL_ONE, 8'h73);
		repeat (20) @(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		`CHK(conversion_active, 1'b0)
		apb(0, OFF_CONTROL_ONE, 0);
		`CHK(rd[7:0], 8'h33)
		$display("Test done: reset in mid sequence");
		conclude();
	end
endmodule // test_adc_sequence_control_regs
